// >>> verilog/sapf_pkg.sv
package sapf_pkg;
    // clock and timing
    localparam int CLK_HZ = 40000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int ZERO_HIGH_MS = 250;
    localparam int ZERO_LOW_MS = 1000;
    localparam int ZERO_HIGH_CYC = ZERO_HIGH_MS * (CLK_HZ / 1000);
    localparam int ZERO_LOW_CYC = ZERO_LOW_MS * (CLK_HZ / 1000);
    localparam int ZCNT_W = 27;
    localparam int TIMEOUT_NS = 20000;
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TCNT_W = 10;

    // frame layout
    localparam int ST_MAX = 18;
    localparam int MT_BITS = 12;
    localparam int ERR_BITS = 3;
    localparam int POS_W = MT_BITS + ST_MAX;
    localparam int WORD_W = POS_W + ERR_BITS;
    localparam int BCNT_W = 6;

    // register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PRESET = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_POSITION = 8'h10;
    localparam logic [7:0] REG_FLAGS = 8'h14;

    // control fields and reset values
    localparam int CTRL_MT_BIT = 0;
    localparam int CTRL_ST_LSB = 1;
    localparam int CTRL_ST_W = 5;
    localparam logic CTRL_MT_RST = 1'b0;
    localparam logic [4:0] CTRL_ST_RST = 5'h12;
    localparam logic [29:0] PRESET_RST = 30'h0;

    // interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_ZERO = 1;
    localparam int IRQ_DETECT = 2;
    localparam int IRQ_ABORT = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    typedef enum {s_idle, s_shift, s_hold} sapf_state_e;
endpackage

// >>> verilog/sapf_sync.sv
`timescale 1ns/10ps
// two flip-flop synchroniser for a group of independent levels
module sapf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // sapf_sync

// >>> verilog/sapf_zero.sv
`timescale 1ns/10ps
// zeroing input qualifier: long low period arms, long high period fires
module sapf_zero #(
    parameter int unsigned HIGH_CYC = sapf_pkg::ZERO_HIGH_CYC,
    parameter int unsigned LOW_CYC = sapf_pkg::ZERO_LOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic set_level,
    output logic zero_pulse
);
    localparam int W = sapf_pkg::ZCNT_W;
    localparam logic [W-1:0] HIGH_T = W'(HIGH_CYC);
    localparam logic [W-1:0] LOW_T = W'(LOW_CYC);

    logic [W-1:0] low_cnt;
    logic [W-1:0] high_cnt;
    logic armed;
    logic fire;

    assign fire = set_level && armed && (high_cnt == HIGH_T);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= '0;
            high_cnt <= '0;
            armed <= 1'b0;
        end else if (!set_level) begin
            high_cnt <= '0;
            if (low_cnt != LOW_T) begin
                low_cnt <= low_cnt + 1'b1;
            end
            armed <= (low_cnt >= LOW_T - 1'b1);
        end else begin
            low_cnt <= '0;
            if (high_cnt != HIGH_T) begin
                high_cnt <= high_cnt + 1'b1;
            end
            if (fire) begin
                armed <= 1'b0;
            end
        end
    end

    // one pulse per qualified hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zero_pulse <= 1'b0;
        end else begin
            zero_pulse <= fire;
        end
    end
endmodule // sapf_zero

// >>> verilog/sapf_frame.sv
`timescale 1ns/10ps
// Behaviour
// - singleturn: position MSB first, then flags
// - speed fault sets its frame flag
// - light source fault sets its flag
// - detection fault since last frame reported
// - detection flag cleared by reporting frame
// - 30-bit format: 12 multiturn, 18 singleturn
// - 27-bit format: 12 multiturn, 15 singleturn
// - multiturn field always twelve bits wide
// - word length is resolution plus three
// - direction input selects counting sense
// - long low then long high zeroes
module sapf_frame #(
    parameter int unsigned ZERO_HIGH_CYC = sapf_pkg::ZERO_HIGH_CYC,
    parameter int unsigned ZERO_LOW_CYC = sapf_pkg::ZERO_LOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ssi_clk_pin,
    output logic ssi_data_out,
    input wire logic dir_pin,
    input wire logic zero_pin,
    input wire logic [29:0] raw_position,
    input wire logic speed_fault_in,
    input wire logic light_source_fault_in,
    input wire logic detection_fault_event,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    localparam int WW = sapf_pkg::WORD_W;
    localparam int PW = sapf_pkg::POS_W;
    localparam int SM = sapf_pkg::ST_MAX;
    localparam int MB = sapf_pkg::MT_BITS;
    localparam int TW = sapf_pkg::TCNT_W;
    localparam int BW = sapf_pkg::BCNT_W;
    localparam int IW = sapf_pkg::IRQ_W;
    localparam logic [TW-1:0] TO_LIMIT = TW'(sapf_pkg::TIMEOUT_CYC);
    localparam logic [4:0] ST_MAX5 = 5'(sapf_pkg::ST_MAX);
    localparam logic [4:0] ERR5 = 5'(sapf_pkg::ERR_BITS);
    localparam logic [BW-1:0] ERR_N = BW'(sapf_pkg::ERR_BITS);
    localparam logic [BW-1:0] MT_N = BW'(sapf_pkg::MT_BITS);
    localparam logic [BW-1:0] WW_N = BW'(sapf_pkg::WORD_W);

    logic [2:0] sync_bus;
    logic ssi_clk_s;
    logic dir_s;
    logic zero_s;
    logic ssi_clk_d;
    logic clk_fall;
    logic clk_rise;
    logic zero_pulse;
    logic mt_en;
    logic [4:0] st_bits;
    logic [PW-1:0] preset;
    logic [IW-1:0] irq_mask;
    logic [IW-1:0] irq_status;
    logic [PW-1:0] dir_pos;
    logic [PW-1:0] offset;
    logic [PW-1:0] next_offset;
    logic [PW-1:0] pos;
    logic [4:0] st_shift;
    logic [SM-1:0] st_val;
    logic [MB-1:0] mt_val;
    logic [BW-1:0] frame_len;
    logic [2:0] err;
    logic [WW-1:0] word_right;
    logic [WW-1:0] word_left;
    logic det_sticky;
    logic det_flag_now;
    sapf_pkg::sapf_state_e state;
    logic [WW-1:0] shreg;
    logic [BW-1:0] bits_left;
    logic [TW-1:0] timer;
    logic timeout;
    logic latch;
    logic frame_done;
    logic frame_abort;
    logic [4:0] wr_st;
    logic st_ok;
    logic [IW-1:0] irq_events;
    logic [IW-1:0] irq_clear;

    // pins from outside the clock domain
    sapf_sync #(.WIDTH(3), .RST_VAL(3'h6)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({ssi_clk_pin, dir_pin, zero_pin}),
        .sync_out(sync_bus)
    );
    assign ssi_clk_s = sync_bus[2];
    assign dir_s = sync_bus[1];
    assign zero_s = sync_bus[0];

    // ssi clock edge detection on the synchronised level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ssi_clk_d <= 1'b1;
        end else begin
            ssi_clk_d <= ssi_clk_s;
        end
    end
    assign clk_fall = ssi_clk_d && !ssi_clk_s;
    assign clk_rise = !ssi_clk_d && ssi_clk_s;

    // zeroing qualifier
    sapf_zero #(.HIGH_CYC(ZERO_HIGH_CYC), .LOW_CYC(ZERO_LOW_CYC)) u_zero (
        .clk(clk),
        .nrst(nrst),
        .set_level(zero_s),
        .zero_pulse(zero_pulse)
    );

    assign dir_pos = dir_s ? raw_position : ('0 - raw_position);
    assign next_offset = dir_pos - preset;
    assign pos = dir_pos - offset;

    // offset taken so that the present position reads preset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset <= '0;
        end else if (zero_pulse) begin
            offset <= next_offset;
        end
    end

    // detection fault held until reported, new event wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            det_sticky <= 1'b0;
        end else if (detection_fault_event) begin
            det_sticky <= 1'b1;
        end else if (latch) begin
            // cleared by the frame that carries it
            det_sticky <= 1'b0;
        end
    end
    assign det_flag_now = det_sticky || detection_fault_event;

    // flags in order speed, light source, detection
    assign err = {speed_fault_in, light_source_fault_in, det_flag_now};

    // singleturn field scaled, multiturn field fixed width
    assign st_shift = ST_MAX5 - st_bits;
    assign st_val = pos[SM-1:0] >> st_shift;
    assign mt_val = mt_en ? pos[PW-1 -: MB] : '0;

    assign frame_len = (mt_en ? MT_N : '0) + BW'(st_bits) + ERR_N;

    // word built right aligned then moved to the top
    assign word_right = (WW'(mt_val) << (st_bits + ERR5)) | (WW'(st_val) << ERR5) | WW'(err);
    assign word_left = word_right << (WW_N - frame_len);

    assign latch = (state == sapf_pkg::s_idle) && clk_fall;

    // transfer timeout restarted by every clock edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer <= '0;
        end else if (state == sapf_pkg::s_idle || clk_fall || clk_rise) begin
            timer <= '0;
        end else if (timer != TO_LIMIT) begin
            timer <= timer + 1'b1;
        end
    end
    assign timeout = (state != sapf_pkg::s_idle) && (timer == TO_LIMIT);
    assign frame_done = timeout && (bits_left == '0);
    assign frame_abort = timeout && (bits_left != '0);

    // latch on first falling edge, shift on each rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= sapf_pkg::s_idle;
            shreg <= '0;
            bits_left <= '0;
            ssi_data_out <= 1'b1;
        end else begin
            case (state)
                sapf_pkg::s_idle: begin
                    ssi_data_out <= 1'b1;
                    if (clk_fall) begin
                        shreg <= word_left;
                        bits_left <= frame_len;
                        state <= sapf_pkg::s_shift;
                    end
                end
                sapf_pkg::s_shift: begin
                    if (timeout) begin
                        ssi_data_out <= 1'b1;
                        bits_left <= '0;
                        state <= sapf_pkg::s_idle;
                    end else if (clk_rise) begin
                        if (bits_left != '0) begin
                            ssi_data_out <= shreg[WW-1];
                            shreg <= {shreg[WW-2:0], 1'b0};
                            bits_left <= bits_left - 1'b1;
                        end else begin
                            ssi_data_out <= 1'b0; // monoflop low after last bit
                            state <= sapf_pkg::s_hold;
                        end
                    end
                end
                sapf_pkg::s_hold: begin
                    ssi_data_out <= 1'b0;
                    if (timeout) begin
                        ssi_data_out <= 1'b1;
                        state <= sapf_pkg::s_idle;
                    end
                end
                default: begin
                    state <= sapf_pkg::s_idle;
                end
            endcase
        end
    end

    // control and preset registers, bad resolution leaves field unchanged
    assign wr_st = reg_wdata[sapf_pkg::CTRL_ST_LSB +: sapf_pkg::CTRL_ST_W];
    assign st_ok = (wr_st != 5'h00) && (wr_st <= ST_MAX5);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mt_en <= sapf_pkg::CTRL_MT_RST;
            st_bits <= sapf_pkg::CTRL_ST_RST;
            preset <= sapf_pkg::PRESET_RST;
            irq_mask <= sapf_pkg::IRQ_MASK_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                sapf_pkg::REG_CTRL: begin
                    mt_en <= reg_wdata[sapf_pkg::CTRL_MT_BIT];
                    if (st_ok) begin
                        st_bits <= wr_st;
                    end
                end
                sapf_pkg::REG_PRESET: begin
                    preset <= reg_wdata[PW-1:0];
                end
                sapf_pkg::REG_IRQ_MASK: begin
                    irq_mask <= reg_wdata[IW-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // sticky interrupt status, set beats write-one clear
    assign irq_events = {frame_abort, detection_fault_event, zero_pulse, frame_done};
    assign irq_clear = (reg_wr && reg_addr == sapf_pkg::REG_IRQ_STATUS) ? reg_wdata[IW-1:0] : '0;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // read data only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                sapf_pkg::REG_CTRL: reg_rdata <= 32'({st_bits, mt_en});
                sapf_pkg::REG_PRESET: reg_rdata <= 32'(preset);
                sapf_pkg::REG_IRQ_STATUS: reg_rdata <= 32'(irq_status);
                sapf_pkg::REG_IRQ_MASK: reg_rdata <= 32'(irq_mask);
                sapf_pkg::REG_POSITION: reg_rdata <= 32'(pos);
                sapf_pkg::REG_FLAGS: reg_rdata <= 32'({state != sapf_pkg::s_idle, err});
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // helpers for the checks below
    logic first_src;
    logic [MB-1:0] mt_src;
    logic [WW-1:0] err_view;
    assign first_src = mt_en ? pos[PW-1] : pos[SM-1];
    assign mt_src = pos[PW-1 -: MB];
    assign err_view = shreg >> (WW_N - bits_left);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_idle_line_high: assert property (
        state == sapf_pkg::s_idle |-> ssi_data_out)
        else $error("data line not high while idle");

    a_hold_line_low: assert property (
        state == sapf_pkg::s_hold |-> !ssi_data_out)
        else $error("data line not low after last bit");

    a_frame_length: assert property (
        latch && !reg_wr |=> bits_left == ERR_N + BW'(st_bits) + (mt_en ? MT_N : '0))
        else $error("frame length differs from resolution plus flags");

    a_first_bit_msb: assert property (
        latch && !reg_wr |=> shreg[WW-1] == $past(first_src))
        else $error("first frame bit is not the position msb");

    a_multiturn_field: assert property (
        latch && mt_en && !reg_wr |=> shreg[WW-1 -: MB] == $past(mt_src))
        else $error("multiturn field wrong");

    a_speed_light_bits: assert property (
        latch |=> err_view[2:1] == $past(err[2:1]))
        else $error("speed or light flag wrong in frame");

    a_detect_bit: assert property (
        latch |=> err_view[0] == $past(det_flag_now))
        else $error("detection flag wrong in frame");

    a_sticky_clear: assert property (
        latch && !detection_fault_event |=> !det_sticky)
        else $error("detection flag not cleared by frame");

    a_sticky_hold: assert property (
        det_sticky && !latch |=> det_sticky)
        else $error("detection flag lost before report");

    a_dir_sense: assert property (
        !dir_s |-> (dir_pos + raw_position) == '0)
        else $error("reverse count sense wrong");

    a_zero_apply: assert property (
        zero_pulse |=> offset == $past(next_offset))
        else $error("zeroing did not load offset");

    c_multiturn_frame: cover property (latch && mt_en);
    c_frame_done: cover property (frame_done);
    c_frame_abort: cover property (frame_abort);
    c_zero: cover property (zero_pulse);
endmodule // sapf_frame

// >>> testbench/sapf_ssi_master.sv
`timescale 1ns/10ps
// ssi master: clock idles high, 200 ns period only inside frames
module sapf_ssi_master (
    output logic ssi_clk,
    input wire logic ssi_data
);
    initial ssi_clk = 1'b1;

    // one frame: falling edge, len bits, one extra rising edge, then idle
    task automatic read_frame(input int len, output logic [32:0] word, output logic idle,
                              output logic tail);
        word = '0;
        idle = ssi_data;
        // one pulse per bit
        // called on a rising clk edge: non-blocking keeps the synchroniser race free
        ssi_clk <= 1'b0;
        #100;
        for (int k = 0; k < len; k++) begin
            ssi_clk <= 1'b1;
            #100;
            // each bit sampled while the clock is high, first bit ends at the top
            word = {word[31:0], ssi_data};
            ssi_clk <= 1'b0;
            #100;
        end
        ssi_clk <= 1'b1;
        #100;
        tail = ssi_data;
        // idle longer than the transfer timeout
        #25000;
    endtask
endmodule // sapf_ssi_master

// >>> testbench/sapf_frame_bench.sv
`timescale 1ns/10ps
// self-checking bench: register tasks plus ssi frames
module sapf_frame_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ssi_clk;
    logic ssi_data;
    logic dir_pin = 1'b1;
    logic zero_pin = 1'b0;
    logic [29:0] raw_position = 30'h0;
    logic speed = 1'b0;
    logic light = 1'b0;
    logic det = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    // 40 mhz clock
    always #12.5 clk = ~clk;

    sapf_frame #(.ZERO_HIGH_CYC(20), .ZERO_LOW_CYC(50)) dut_u (
        .clk(clk),
        .nrst(nrst),
        .ssi_clk_pin(ssi_clk),
        .ssi_data_out(ssi_data),
        .dir_pin(dir_pin),
        .zero_pin(zero_pin),
        .raw_position(raw_position),
        .speed_fault_in(speed),
        .light_source_fault_in(light),
        .detection_fault_event(det),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .irq(irq)
    );

    sapf_ssi_master ssi_u (
        .ssi_clk(ssi_clk),
        .ssi_data(ssi_data)
    );

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            end_of_test();
        end
    end

    // value compare
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // expected word: turns, top st bits of singleturn, then the three flags
    function automatic logic [32:0] ew(input logic mt, input int st, input logic [2:0] f);
        logic [32:0] w;
        w = 33'(raw_position[17:0] >> (18 - st));
        if (mt) begin
            w = w | (33'(raw_position[29:18]) << st);
        end
        return (w << 3) | 33'(f);
    endfunction

    // one frame with idle level and trailing low level checked
    task automatic frame(input int len, input logic [32:0] exp);
        logic [32:0] w;
        logic idle;
        logic tail;
        ssi_u.read_frame(len, w, idle, tail);
        chk(w, exp);
        chk(w >> 3, exp >> 3);
        // idle high, low after last bit
        chk(33'(idle), 33'h1);
        chk(33'(tail), 33'h0);
    endtask

    initial begin
        logic [31:0] d;
        logic [29:0] n;
        logic [32:0] e;
        logic [32:0] w;
        logic idle;
        logic tail;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(sapf_pkg::REG_CTRL, d);
        chk(33'(d), 33'h24);
        rd(sapf_pkg::REG_IRQ_MASK, d);
        chk(33'(d), 33'h0);
        rd(8'h20, d);
        chk(33'(d), 33'h0);
        wr(sapf_pkg::REG_IRQ_MASK, 32'h1);
        @(posedge clk);
        raw_position <= 30'h1a5c3e97;
        speed <= 1'b1;
        det <= 1'b1;
        @(posedge clk);
        det <= 1'b0;
        frame(21, ew(1'b0, 18, 3'b101));
        chk(33'(irq), 33'h1);
        rd(sapf_pkg::REG_IRQ_STATUS, d);
        chk(33'(d[0]), 33'h1);
        wr(sapf_pkg::REG_IRQ_STATUS, 32'h1);
        @(posedge clk);
        chk(33'(irq), 33'h0);
        @(posedge clk);
        speed <= 1'b0;
        light <= 1'b1;
        frame(21, ew(1'b0, 18, 3'b010));
        @(posedge clk);
        light <= 1'b0;
        wr(sapf_pkg::REG_CTRL, 32'h25);
        frame(33, ew(1'b1, 18, 3'b000));
        wr(sapf_pkg::REG_CTRL, 32'h1f);
        frame(30, ew(1'b1, 15, 3'b000));
        wr(sapf_pkg::REG_CTRL, 32'h1a);
        frame(16, ew(1'b0, 13, 3'b000));
        wr(sapf_pkg::REG_CTRL, 32'h1);
        rd(sapf_pkg::REG_CTRL, d);
        chk(33'(d), 33'h1b);
        // flag register and detection event interrupt
        wr(sapf_pkg::REG_IRQ_STATUS, 32'hf);
        @(posedge clk);
        speed <= 1'b1;
        light <= 1'b1;
        det <= 1'b1;
        @(posedge clk);
        det <= 1'b0;
        rd(sapf_pkg::REG_FLAGS, d);
        chk(33'(d), 33'h7);
        rd(sapf_pkg::REG_IRQ_STATUS, d);
        chk(33'(d), 33'h4);
        @(posedge clk);
        speed <= 1'b0;
        light <= 1'b0;
        // cut frame: timeout mid-frame aborts and the line returns high
        e = ew(1'b1, 13, 3'b000);
        ssi_u.read_frame(5, w, idle, tail);
        chk(w, e >> 23);
        chk(33'(tail), 33'(e[22]));
        chk(33'(ssi_data), 33'h1);
        rd(sapf_pkg::REG_IRQ_STATUS, d);
        chk(33'(d[3]), 33'h1);
        // reverse counting sense negates the position
        @(posedge clk);
        dir_pin <= 1'b0;
        repeat (5) @(posedge clk);
        n = -raw_position;
        rd(sapf_pkg::REG_POSITION, d);
        chk(33'(d), 33'({2'b00, n}));
        @(posedge clk);
        dir_pin <= 1'b1;
        repeat (5) @(posedge clk);
        // long low already seen, long high zeroes to preset
        wr(sapf_pkg::REG_PRESET, 32'h0155aa00);
        @(posedge clk);
        zero_pin <= 1'b1;
        repeat (40) @(posedge clk);
        rd(sapf_pkg::REG_POSITION, d);
        chk(33'(d), 33'h0155aa00);
        rd(sapf_pkg::REG_IRQ_STATUS, d);
        chk(33'(d[1]), 33'h1);
        // short low period must not arm a second zeroing
        wr(sapf_pkg::REG_PRESET, 32'h0);
        @(posedge clk);
        zero_pin <= 1'b0;
        repeat (10) @(posedge clk);
        zero_pin <= 1'b1;
        repeat (40) @(posedge clk);
        rd(sapf_pkg::REG_POSITION, d);
        chk(33'(d), 33'h0155aa00);
        end_of_test();
    end
endmodule // sapf_frame_bench
